//--- verilog/gpfc_regs.svh
// register map, field positions, reset values and timing counts of the pin function block
// assumes a word-addressed Avalon-MM slave; byte address is four times each index
`ifndef GPFC_REGS_SVH
`define GPFC_REGS_SVH

`define GPFC_IDX_CTRL         32'h1200_0000
`define GPFC_IDX_HIGH_DD      32'h1200_0001
`define GPFC_IDX_LOW_DIR      32'h12c0_0000
`define GPFC_IDX_MID_DIR      32'h12c0_0001
`define GPFC_IDX_LOW_DATA     32'h12c0_0002
`define GPFC_IDX_MID_DATA     32'h12c0_0003
`define GPFC_IDX_EXP_DATA     32'h12c0_0004
`define GPFC_IDX_EXP_DATA_INC 32'h12c0_0005

`define GPFC_CTRL_UART0       0
`define GPFC_CTRL_IRQ         1
`define GPFC_CTRL_DRQ         2
`define GPFC_CTRL_CLKOUT      3

`define GPFC_HIGH_DATA_LSB    0
`define GPFC_HIGH_DIR_LSB     4

`define GPFC_RST_BYTE         8'h00

`define GPFC_CLK_PERIOD_NS    10
`define GPFC_CLK_HZ           64'd100000000
`define GPFC_CLKOUT_HZ        64'd14745600
`define GPFC_EXP_CYCLE_NS     100
`define GPFC_EXP_CYCLES       ((`GPFC_EXP_CYCLE_NS + `GPFC_CLK_PERIOD_NS - 1) / `GPFC_CLK_PERIOD_NS)
`define GPFC_NCO_STEP         32'(((`GPFC_CLKOUT_HZ << 32) + `GPFC_CLK_HZ / 64'd2) / `GPFC_CLK_HZ)

`endif

//--- verilog/gpfc_pkg.sv
// types shared by the pin function block
// assumes nothing beyond the register header
package gpfc_pkg;
	typedef logic [7:0] gpfc_byte_t;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_EXP  = 3'b010,
		ST_DONE = 3'b100
	} gpfc_state_t;
endpackage

//--- verilog/gpfc_sync.sv
// two flip-flop synchroniser for pin inputs
// assumes inputs are asynchronous to clk
`timescale 1ns/100ps
module gpfc_sync #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta <= '0;
			q    <= '0;
		end
		else
		begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

//--- verilog/gpfc_top.sv
// twenty-line gpio block with alternate pin functions and expansion bus port
// assumes one 100 MHz clock, Avalon-MM master on the same clock, pins resolved outside from out/oe
//
// Function
// RULE_01: the low group direction register sets each of its eight lines to output with a one and input with a zero.
// RULE_02: the middle group direction register sets each of its eight lines to output with a one and input with a zero.
// RULE_03: the middle group data register drives output lines on write and returns the line levels on read.
// RULE_04: the low group data register is also the eight-bit expansion bus address register, on the same lines.
// RULE_05: the high group register holds the four line data values in bits 3:0.
// RULE_06: the high group register holds the four line directions in bits 7:4, one meaning output.
// RULE_07: control bit 0 puts uart 0 transmit and receive on high lines two and three.
// RULE_08: control bit 1 makes middle line three an interrupt request input.
// RULE_09: control bit 2 makes middle line four a dma request input.
// RULE_10: control bit 3 drives a 14.7456 MHz clock on middle line five.
// RULE_11: an access to the auto-increment data port runs an expansion bus cycle then increments the address.
// RULE_12: an alternate function overrides the general direction and data of its line.
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/100ps
`include "gpfc_regs.svh"
module gpfc_top #(
	parameter int EXP_CYCLES = `GPFC_EXP_CYCLES
) (
	input  wire logic               clk,
	input  wire logic               rstn,
	input  wire logic [31:0]        avs_address,
	input  wire logic               avs_read,
	input  wire logic               avs_write,
	input  wire logic [31:0]        avs_writedata,
	output logic      [31:0]        avs_readdata,
	output logic                    avs_waitrequest,
	input  wire logic [7:0]         low_group_lines_in,
	output logic      [7:0]         low_group_lines_out,
	output logic      [7:0]         low_group_lines_oe,
	input  wire logic [7:0]         mid_group_lines_in,
	output logic      [7:0]         mid_group_lines_out,
	output logic      [7:0]         mid_group_lines_oe,
	input  wire logic [3:0]         high_group_lines_in,
	output logic      [3:0]         high_group_lines_out,
	output logic      [3:0]         high_group_lines_oe,
	input  wire gpfc_pkg::gpfc_byte_t expansion_bus_data_in,
	output gpfc_pkg::gpfc_byte_t    expansion_bus_data_out,
	output logic                    expansion_bus_data_oe,
	output logic                    expansion_bus_rd_n,
	output logic                    expansion_bus_wr_n,
	input  wire logic               uart0_txd,
	output logic                    uart0_rxd,
	output logic                    irq_req,
	output logic                    dma_req
);
	import gpfc_pkg::*;

	gpfc_byte_t  ctrl;
	gpfc_byte_t  high_dd;
	gpfc_byte_t  low_dir;
	gpfc_byte_t  mid_dir;
	gpfc_byte_t  low_data;
	gpfc_byte_t  mid_data;
	gpfc_state_t state;
	gpfc_state_t next_state;
	logic [15:0] cnt;
	logic [31:0] nco_acc;
	gpfc_byte_t  low_sync;
	gpfc_byte_t  mid_sync;
	logic [3:0]  high_sync;
	gpfc_byte_t  exp_sync;

	gpfc_sync #(.W(8)) u_sync_low (.clk(clk), .rstn(rstn), .d(low_group_lines_in), .q(low_sync));
	gpfc_sync #(.W(8)) u_sync_mid (.clk(clk), .rstn(rstn), .d(mid_group_lines_in), .q(mid_sync));
	gpfc_sync #(.W(4)) u_sync_high (.clk(clk), .rstn(rstn), .d(high_group_lines_in), .q(high_sync));
	gpfc_sync #(.W(8)) u_sync_exp (.clk(clk), .rstn(rstn), .d(expansion_bus_data_in), .q(exp_sync));

	// address decode
	wire hit_ctrl     = avs_address == `GPFC_IDX_CTRL;
	wire hit_high     = avs_address == `GPFC_IDX_HIGH_DD;
	wire hit_low_dir  = avs_address == `GPFC_IDX_LOW_DIR;
	wire hit_mid_dir  = avs_address == `GPFC_IDX_MID_DIR;
	wire hit_low_data = avs_address == `GPFC_IDX_LOW_DATA;
	wire hit_mid_data = avs_address == `GPFC_IDX_MID_DATA;
	wire hit_exp_inc  = avs_address == `GPFC_IDX_EXP_DATA_INC;
	wire hit_exp      = hit_exp_inc || avs_address == `GPFC_IDX_EXP_DATA;
	wire req          = avs_read || avs_write;
	wire cnt_last     = cnt == 16'(EXP_CYCLES - 1);
	wire in_done      = state == ST_DONE;
	wire wr_now       = in_done && avs_write;

	// data reads return line levels, not the stored output value
	wire gpfc_byte_t rd_mux =
		hit_ctrl     ? ctrl :
		hit_high     ? {high_dd[7:4], high_sync} :
		hit_low_dir  ? low_dir :
		hit_mid_dir  ? mid_dir :
		hit_low_data ? low_sync :
		hit_mid_data ? mid_sync : `GPFC_RST_BYTE; // RULE_03

	assign avs_waitrequest = req && !in_done;

	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:
			begin
				if (req)
					next_state = hit_exp ? ST_EXP : ST_DONE; // RULE_11
			end
			ST_EXP:
			begin
				if (cnt_last)
					next_state = ST_DONE;
			end
			ST_DONE:
				next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state <= ST_IDLE;
			cnt   <= 16'h0000;
		end
		else
		begin
			state <= next_state;
			cnt   <= (state == ST_EXP) ? cnt + 16'h0001 : 16'h0000;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			avs_readdata <= 32'h0000_0000;
		else if (state == ST_IDLE && avs_read && !hit_exp)
			avs_readdata <= {24'h00_0000, rd_mux};
		else if (state == ST_EXP && cnt_last && avs_read)
			avs_readdata <= {24'h00_0000, exp_sync}; // RULE_11
	end

	// writes take effect on the edge after waitrequest drops, the one that completes the transfer
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl     <= `GPFC_RST_BYTE;
			high_dd  <= `GPFC_RST_BYTE;
			low_dir  <= `GPFC_RST_BYTE;
			mid_dir  <= `GPFC_RST_BYTE;
			mid_data <= `GPFC_RST_BYTE;
		end
		else if (wr_now)
		begin
			if (hit_ctrl)
				ctrl <= avs_writedata[7:0];
			if (hit_high)
				high_dd <= avs_writedata[7:0]; // RULE_05 RULE_06
			if (hit_low_dir)
				low_dir <= avs_writedata[7:0]; // RULE_01
			if (hit_mid_dir)
				mid_dir <= avs_writedata[7:0]; // RULE_02
			if (hit_mid_data)
				mid_data <= avs_writedata[7:0]; // RULE_03
		end
	end

	// one storage serves both gpio data and bus address
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			low_data <= `GPFC_RST_BYTE;
		else if (wr_now && hit_low_data)
			low_data <= avs_writedata[7:0]; // RULE_04
		else if (in_done && hit_exp_inc)
			low_data <= low_data + 8'h01; // RULE_11
	end

	// expansion bus strobes span the whole cycle
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			expansion_bus_rd_n     <= 1'b1;
			expansion_bus_wr_n     <= 1'b1;
			expansion_bus_data_oe  <= 1'b0;
			expansion_bus_data_out <= `GPFC_RST_BYTE;
		end
		else
		begin
			expansion_bus_rd_n     <= !(next_state == ST_EXP && avs_read);
			expansion_bus_wr_n     <= !(next_state == ST_EXP && avs_write);
			expansion_bus_data_oe  <= next_state == ST_EXP && avs_write;
			expansion_bus_data_out <= avs_writedata[7:0];
		end
	end

	// phase accumulator: average rate set by the rounded 32-bit step, edges jitter by one 10 ns period
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			nco_acc <= 32'h0000_0000;
		else if (ctrl[`GPFC_CTRL_CLKOUT])
			nco_acc <= nco_acc + `GPFC_NCO_STEP; // RULE_10
		else
			nco_acc <= 32'h0000_0000;
	end

	// pin drive with alternate functions taking priority
	gpfc_byte_t next_mid_out;
	gpfc_byte_t next_mid_oe;
	logic [3:0] next_high_out;
	logic [3:0] next_high_oe;

	always_comb
	begin
		next_mid_out  = mid_data;
		next_mid_oe   = mid_dir;
		next_high_out = high_dd[`GPFC_HIGH_DATA_LSB +: 4];
		next_high_oe  = high_dd[`GPFC_HIGH_DIR_LSB +: 4];
		if (ctrl[`GPFC_CTRL_UART0])
		begin
			next_high_out[2] = uart0_txd; // RULE_07 RULE_12
			next_high_oe[2]  = 1'b1;
			next_high_oe[3]  = 1'b0;
		end
		if (ctrl[`GPFC_CTRL_IRQ])
			next_mid_oe[3] = 1'b0; // RULE_08 RULE_12
		if (ctrl[`GPFC_CTRL_DRQ])
			next_mid_oe[4] = 1'b0; // RULE_09 RULE_12
		if (ctrl[`GPFC_CTRL_CLKOUT])
		begin
			next_mid_out[5] = nco_acc[31]; // RULE_10 RULE_12
			next_mid_oe[5]  = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			low_group_lines_out  <= `GPFC_RST_BYTE;
			low_group_lines_oe   <= `GPFC_RST_BYTE;
			mid_group_lines_out  <= `GPFC_RST_BYTE;
			mid_group_lines_oe   <= `GPFC_RST_BYTE;
			high_group_lines_out <= 4'h0;
			high_group_lines_oe  <= 4'h0;
			uart0_rxd            <= 1'b1;
			irq_req              <= 1'b0;
			dma_req              <= 1'b0;
		end
		else
		begin
			low_group_lines_out  <= low_data; // RULE_04
			low_group_lines_oe   <= low_dir; // RULE_01
			mid_group_lines_out  <= next_mid_out;
			mid_group_lines_oe   <= next_mid_oe;
			high_group_lines_out <= next_high_out;
			high_group_lines_oe  <= next_high_oe;
			uart0_rxd            <= ctrl[`GPFC_CTRL_UART0] ? high_sync[3] : 1'b1; // RULE_07
			irq_req              <= ctrl[`GPFC_CTRL_IRQ] && mid_sync[3]; // RULE_08
			dma_req              <= ctrl[`GPFC_CTRL_DRQ] && mid_sync[4]; // RULE_09
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	AST_LOW_DIR: assert property ((wr_now && hit_low_dir) |=> ##1 // RULE_01
		(low_group_lines_oe == $past(avs_writedata[7:0], 2)))
		else $error("low group direction not applied");
	AST_MID_DIR: assert property ((wr_now && hit_mid_dir && ctrl == 8'h00) |=> ##1 // RULE_02
		(mid_group_lines_oe == $past(avs_writedata[7:0], 2)))
		else $error("mid group direction not applied");
	AST_MID_READ: assert property ((state == ST_IDLE && avs_read && hit_mid_data) |=> // RULE_03
		(avs_readdata[7:0] == $past(mid_sync) && !avs_waitrequest))
		else $error("mid group read does not show line levels");
	AST_LOW_ADDR: assert property ((wr_now && hit_low_data) |=> ##1 // RULE_04
		(low_group_lines_out == $past(avs_writedata[7:0], 2)))
		else $error("low group data or bus address not driven");
	AST_HIGH_DATA: assert property ((wr_now && hit_high && !ctrl[0]) |=> ##1 // RULE_05
		(high_group_lines_out == $past(avs_writedata[3:0], 2)))
		else $error("high group data not driven");
	AST_HIGH_DIR: assert property ((wr_now && hit_high) |=> ##1 // RULE_06
		(high_group_lines_oe[1:0] == $past(avs_writedata[5:4], 2)))
		else $error("high group direction not applied");
	AST_UART_PINS: assert property (ctrl[0] |=> (high_group_lines_oe[2] && !high_group_lines_oe[3] // RULE_07
		&& uart0_rxd == $past(high_sync[3])))
		else $error("uart pins not routed");
	AST_IRQ: assert property ((ctrl[1] && mid_sync[3]) |=> (irq_req && !mid_group_lines_oe[3])) // RULE_08
		else $error("interrupt input not routed");
	AST_DRQ: assert property ((ctrl[2] && mid_sync[4]) |=> (dma_req && !mid_group_lines_oe[4])) // RULE_09
		else $error("dma request not routed");
	// clearing the enable mid-low leaves the line at its data value, so the check ends with the enable
	AST_CLKOUT: assert property ((ctrl[3] && !mid_group_lines_out[5]) [*2] |-> // RULE_10
		##[1:6] (mid_group_lines_out[5] || !ctrl[3]))
		else $error("clock output stuck low");
	AST_EXP_INC: assert property ((in_done && hit_exp_inc) |=> // RULE_11
		(low_data == $past(low_data) + 8'h01))
		else $error("bus address not incremented");
	AST_EXP_CYCLE: assert property ((state == ST_IDLE && req && hit_exp) |=> // RULE_11
		(!expansion_bus_rd_n || !expansion_bus_wr_n) && avs_waitrequest)
		else $error("bus cycle not started");
	AST_OVERRIDE: assert property ((ctrl[3] && !mid_dir[5]) |=> mid_group_lines_oe[5]) // RULE_12
		else $error("alternate function did not override direction");

	COV_EXP_INC: cover property (in_done && hit_exp_inc && avs_read);
	COV_EXP_WR: cover property (in_done && hit_exp && avs_write);
	COV_UART: cover property (ctrl[0] && high_group_lines_oe[2]);
	COV_CLK: cover property (ctrl[3] && $rose(mid_group_lines_out[5]));
endmodule

//--- verification/gpfc_pins_model.sv
// outside world on the twenty lines and the expansion bus
// assumes the bench sets what the outside drives on lines the block leaves undriven
`timescale 1ns/100ps
module gpfc_pins_model (
	input  wire logic        clk,
	input  wire logic [19:0] pin_out,
	input  wire logic [19:0] pin_oe,
	input  wire logic [19:0] pin_ext,
	output logic      [19:0] pin_in,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic        data_oe,
	input  wire logic [7:0]  data_out,
	output logic      [7:0]  data_in,
	output logic      [15:0] wr_seen
);
	logic [7:0] toggle = 8'h3c;

	assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_ext);
	// bus data is only valid while read strobe is low; otherwise it churns so stale capture shows
	assign data_in = !rd_n ? (pin_out[7:0] ^ 8'h5a) : toggle;

	always @(posedge clk)
	begin
		toggle <= ~toggle;
		if (!wr_n && data_oe)
			wr_seen <= {pin_out[7:0], data_out};
	end
endmodule

//--- verification/gpfc_top_bench.sv
// self-checking bench for the pin function block
// assumes the pin model resolves every line from out/oe and the bench's outside levels
`timescale 1ns/100ps
`include "gpfc_regs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module gpfc_top_bench;
	import gpfc_pkg::*;
	logic        clk, rstn, avs_read, avs_write, txd, rxd, irq, dma, wreq, rd_n, wr_n, data_oe;
	logic [31:0] avs_address, avs_writedata, avs_readdata, rd;
	logic [19:0] p_ext;
	wire  [19:0] p_out, p_oe, p_in;
	gpfc_byte_t  x_in, x_out;
	logic [15:0] wr_seen;
	int          n_errors = 0;
	int          n_tests = 0;
	int          n_rd = 0;

	// short bus cycle keeps the run brief; expectations below use the same value
	gpfc_top #(.EXP_CYCLES(4)) dut (
		.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(wreq),
		.low_group_lines_in(p_in[7:0]), .low_group_lines_out(p_out[7:0]), .low_group_lines_oe(p_oe[7:0]),
		.mid_group_lines_in(p_in[15:8]), .mid_group_lines_out(p_out[15:8]), .mid_group_lines_oe(p_oe[15:8]),
		.high_group_lines_in(p_in[19:16]), .high_group_lines_out(p_out[19:16]),
		.high_group_lines_oe(p_oe[19:16]), .expansion_bus_data_in(x_in), .expansion_bus_data_out(x_out),
		.expansion_bus_data_oe(data_oe), .expansion_bus_rd_n(rd_n), .expansion_bus_wr_n(wr_n),
		.uart0_txd(txd), .uart0_rxd(rxd), .irq_req(irq), .dma_req(dma));

	gpfc_pins_model pins (.clk(clk), .pin_out(p_out), .pin_oe(p_oe), .pin_ext(p_ext), .pin_in(p_in),
		.rd_n(rd_n), .wr_n(wr_n), .data_oe(data_oe), .data_out(x_out), .data_in(x_in), .wr_seen(wr_seen));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
		if (rd_n === 1'b0)
			n_rd++;

	task automatic stop_test;
		if (n_errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// one avalon transfer; an extra edge after release avoids re-driving in the same time step
	task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] d);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h000000, d};
		@(posedge clk);
		// no cycle count assumed; only the watchdog ends a hung wait
		while (wreq !== 1'b0)
			@(posedge clk);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rchk(input string nm, input logic [31:0] a, input logic [7:0] e);
		xfer(a, 1'b0, 8'h00);
		`CHK(nm, {24'h000000, e}, rd)
	endtask

	// pins are registered after the register, then synchronised on the way back
	task automatic settle;
		repeat (4) @(posedge clk);
	endtask

	task automatic t_reset;
		logic [31:0] idx [6];
		idx = '{`GPFC_IDX_CTRL, `GPFC_IDX_HIGH_DD, `GPFC_IDX_LOW_DIR, `GPFC_IDX_MID_DIR,
			`GPFC_IDX_LOW_DATA, `GPFC_IDX_MID_DATA};
		foreach (idx[i])
			rchk("reset value", idx[i], `GPFC_RST_BYTE);
		`CHK("reset oe", 20'h00000, p_oe)
		`CHK("reset rxd", 1'b1, rxd)
	endtask

	task automatic t_dirdata;
		p_ext <= 20'h03cc3;
		xfer(`GPFC_IDX_LOW_DIR, 1'b1, 8'hf0);
		xfer(`GPFC_IDX_LOW_DATA, 1'b1, 8'ha5);
		xfer(`GPFC_IDX_MID_DIR, 1'b1, 8'h0f);
		xfer(`GPFC_IDX_MID_DATA, 1'b1, 8'h5a);
		settle;
		`CHK("low oe", 8'hf0, p_oe[7:0])
		`CHK("mid oe", 8'h0f, p_oe[15:8])
		`CHK("low out", 8'ha0, p_out[7:0] & p_oe[7:0])
		`CHK("mid out", 8'h0a, p_out[15:8] & p_oe[15:8])
		rchk("low dir", `GPFC_IDX_LOW_DIR, 8'hf0);
		rchk("mid dir", `GPFC_IDX_MID_DIR, 8'h0f);
		rchk("low data", `GPFC_IDX_LOW_DATA, 8'ha3);
		rchk("mid data", `GPFC_IDX_MID_DATA, 8'h3a);
	endtask

	task automatic t_high;
		p_ext[19:16] <= 4'h9;
		xfer(`GPFC_IDX_HIGH_DD, 1'b1, 8'h6c);
		settle;
		`CHK("high oe", 4'h6, p_oe[19:16])
		`CHK("high out", 4'h4, p_out[19:16] & p_oe[19:16])
		rchk("high reg", `GPFC_IDX_HIGH_DD, 8'h6d);
	endtask

	task automatic t_alt;
		int  n;
		logic prev;
		xfer(`GPFC_IDX_MID_DIR, 1'b1, 8'hff);
		xfer(`GPFC_IDX_MID_DATA, 1'b1, 8'h00);
		xfer(`GPFC_IDX_HIGH_DD, 1'b1, 8'h70);
		p_ext[15:8] <= 8'h18;
		p_ext[19] <= 1'b0;
		txd <= 1'b1;
		xfer(`GPFC_IDX_CTRL, 1'b1, 8'h07);
		settle;
		`CHK("uart oe", 2'b01, p_oe[19:18])
		`CHK("uart tx", 1'b1, p_out[18])
		`CHK("uart rx", 1'b0, rxd)
		`CHK("irq", 1'b1, irq)
		`CHK("irq line oe", 1'b0, p_oe[11])
		`CHK("dma", 1'b1, dma)
		txd <= 1'b0;
		p_ext[19] <= 1'b1;
		settle;
		`CHK("uart tx low", 1'b0, p_out[18])
		`CHK("uart rx high", 1'b1, rxd)
		xfer(`GPFC_IDX_CTRL, 1'b1, 8'h08);
		settle;
		`CHK("irq off", 1'b0, irq)
		`CHK("mid oe back", 8'hff, p_oe[15:8])
		xfer(`GPFC_IDX_MID_DIR, 1'b1, 8'hdf);
		settle;
		`CHK("clk oe over dir", 8'hff, p_oe[15:8])
		n = 0;
		prev = p_out[13];
		repeat (1000)
		begin
			@(posedge clk);
			if (p_out[13] && !prev)
				n++;
			prev = p_out[13];
		end
		// 14.7456 MHz over 1000 cycles of 10 ns is 147.456 rising edges
		`CHK("clock rate", 1'b1, n >= 147 && n <= 148)
		xfer(`GPFC_IDX_CTRL, 1'b1, 8'h00);
	endtask

	task automatic t_exp;
		xfer(`GPFC_IDX_LOW_DIR, 1'b1, 8'hff);
		xfer(`GPFC_IDX_LOW_DATA, 1'b1, 8'hff);
		settle;
		n_rd = 0;
		xfer(`GPFC_IDX_EXP_DATA_INC, 1'b0, 8'h00);
		`CHK("exp read", 32'h000000a5, rd)
		`CHK("exp strobe", 4, n_rd)
		settle;
		`CHK("addr wrap", 8'h00, p_out[7:0])
		xfer(`GPFC_IDX_EXP_DATA_INC, 1'b1, 8'h3c);
		settle;
		`CHK("exp write", 16'h003c, wr_seen)
		`CHK("addr inc", 8'h01, p_out[7:0])
		xfer(`GPFC_IDX_EXP_DATA, 1'b0, 8'h00);
		`CHK("plain read", 32'h0000005b, rd)
		settle;
		`CHK("addr held", 8'h01, p_out[7:0])
	endtask

	task automatic t_unmapped;
		xfer(32'h12c0_0007, 1'b1, 8'hff);
		rchk("unmapped", 32'h12c0_0007, 8'h00);
		rchk("ctrl kept", `GPFC_IDX_CTRL, 8'h00);
	endtask

	initial
	begin
		rstn = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 32'h00000000;
		avs_writedata = 32'h00000000;
		txd = 1'b0;
		p_ext = 20'h00000;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_reset;
		t_dirdata;
		t_high;
		t_alt;
		t_exp;
		t_unmapped;
		stop_test;
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		stop_test;
	end
endmodule
